// *** dv/fetch_model.sv ***
// Fetch stage and datapath status model feeding the decoder
`timescale 1ns/1ns
module fetch_model
  import instr_decode_pkg::*;
(
  // Clock
  input  wire logic          sys_clk,
  // Word and status towards the decoder
  output logic [WORD_W-1:0]  instrWord,
  output logic               instrValid,
  output logic               zeroFlag,
  output logic               carryFlag,
  output logic               ovfFlag,
  output logic               negFlag,
  output logic               testBit
);
  // Quiet at time zero
  initial {instrWord, instrValid, zeroFlag, carryFlag, ovfFlag, negFlag, testBit} = '0;
  // One word for one cycle; the word line is scrambled after release
  task automatic send(input logic [WORD_W-1:0] w, input logic [4:0] f);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord <= w;
    {zeroFlag, carryFlag, ovfFlag, negFlag, testBit} <= f;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    instrWord <= ~w;
  endtask
endmodule

// *** dv/instr_word_decoder_chk.sv ***
// Concurrent checks on the decoder's output ports
`timescale 1ns/1ns
module instr_word_decoder_chk
  import instr_decode_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Decode port
  input wire logic       instrValid,
  input wire logic       decodeValid,
  input wire op_class_e  opClass,
  input wire logic [1:0] cycleCount,
  input wire logic [7:0] flagMask,
  input wire logic       skippedWord,
  input wire logic       prescalerClear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Decoded report of a class group
  sequence s_two;
    decodeValid && opClass inside {OP_CALL, OP_GOTO, OP_PTR_LD, OP_IRQ_RET,
      OP_RETURN, OP_LIT_RET, OP_TBL_READ, OP_TBL_WRITE};
  endsequence
  sequence s_quiet;
    decodeValid && opClass inside {OP_LIT_MOV, OP_LIT_MUL, OP_BANK_LD, OP_POP, OP_PUSH};
  endsequence
  property p_pulse; decodeValid |-> $past(instrValid); endproperty
  property p_two; s_two |-> cycleCount == CYC_TWO; endproperty
  property p_quiet; s_quiet |-> flagMask == MASK_NONE && cycleCount == CYC_ONE; endproperty
  property p_arith;
    decodeValid && opClass inside {OP_LIT_ADD, OP_LIT_SUB} |-> flagMask == MASK_ARITH;
  endproperty
  property p_logic;
    decodeValid && opClass inside {OP_LIT_AND, OP_LIT_IOR, OP_LIT_XOR}
      |-> flagMask == MASK_LOGIC && cycleCount == CYC_ONE;
  endproperty
  property p_power;
    decodeValid && opClass inside {OP_SLEEP, OP_WDT_CLR} |-> flagMask == MASK_POWER;
  endproperty
  property p_irq; decodeValid && opClass == OP_IRQ_RET |-> flagMask == MASK_IRQ; endproperty
  property p_skip; decodeValid && skippedWord |-> opClass == OP_NOP; endproperty
  property p_pre; prescalerClear |-> decodeValid; endproperty
  a_pulse: assert property (p_pulse) else $error("report without word");
  a_two: assert property (p_two) else $error("two-cycle class miscounted");
  a_quiet: assert property (p_quiet) else $error("quiet class flags");
  a_arith: assert property (p_arith) else $error("arith mask");
  a_logic: assert property (p_logic) else $error("logic mask");
  a_power: assert property (p_power) else $error("power mask");
  a_irq: assert property (p_irq) else $error("irq mask");
  a_skip: assert property (p_skip) else $error("skipped not nop");
  a_pre: assert property (p_pre) else $error("stray prescaler clear");
endmodule
bind instr_word_decoder instr_word_decoder_chk CHK (.sys_clk(sys_clk), .rst_b(rst_b),
  .instrValid(instrValid), .decodeValid(decodeValid), .opClass(opClass),
  .cycleCount(cycleCount), .flagMask(flagMask), .skippedWord(skippedWord),
  .prescalerClear(prescalerClear));

// *** dv/instr_word_decoder_tb_top.sv ***
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ns
module instr_word_decoder_tb_top;
  import instr_decode_pkg::*;
  // ==========================================================
  // Wiring
  logic              sys_clk = 0, rst_b = 0, hwrite = 0;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]        htrans = 0, cycleCount;
  logic [WORD_W-1:0] instrWord;
  logic              instrValid, zeroFlag, carryFlag, ovfFlag, negFlag, testBit;
  logic              decodeValid, destBit, accessBit, fastSelect, skippedWord;
  logic              usePinLevel, prescalerClear, hreadyout, hresp;
  op_class_e         opClass;
  logic [7:0]        fileAddr, flagMask;
  logic [2:0]        bitIndex;
  logic [LIT_W-1:0]  literal;
  logic [TGT_W-1:0]  targetAddr;
  int                bad_count = 0, samples_checked = 0, cyc = 0;
  fetch_model FM (.sys_clk, .instrWord, .instrValid, .zeroFlag, .carryFlag, .ovfFlag,
    .negFlag, .testBit);
  instr_word_decoder DUT (.sys_clk, .rst_b, .instrWord, .instrValid, .zeroFlag,
    .carryFlag, .ovfFlag, .negFlag, .testBit, .decodeValid, .opClass, .fileAddr,
    .bitIndex, .destBit, .accessBit, .literal, .targetAddr, .fastSelect, .cycleCount,
    .flagMask, .skippedWord, .usePinLevel, .prescalerClear, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp);
  initial forever #5 sys_clk = ~sys_clk;
  // Hang guard, far above the run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      $display("[ERR] %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One AHB single transfer; read data lands in q
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Send a word, wait for its report, compare class, cycles, flags
  task automatic run(input logic [15:0] w, input logic [4:0] f, input op_class_e op,
                     input logic [1:0] cy, input logic [7:0] m);
    int i;
    FM.send(w, f);
    #1;
    for (i = 0; i < 3 && decodeValid !== 1'b1; i++) @(posedge sys_clk) #1;
    chk(decodeValid, 1);
    chk(opClass, op);
    chk(cycleCount, cy);
    chk(flagMask, m);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1;
    bus(0, REG_PORT, 0);
    chk(q, 32'h0580);
    chk({hresp, hreadyout}, 2'h1);
    bus(0, 32'h40, 0);
    chk(q, 0);
    run(16'h9B45, 0, OP_BIT_CLEAR, 1, 0);
    chk({bitIndex, accessBit, fileAddr, destBit}, 13'h168B);
    run(16'h8000, 0, OP_BIT_SET, 1, 0);
    run(16'h7000, 0, OP_BIT_TGL, 1, 0);
    run(16'hB000, 5'h01, OP_SKIP_CLR, 1, 0);
    run(16'hA000, 5'h01, OP_SKIP_SET, 2, 0);
    run(16'h0F15, 0, OP_NOP, 1, 0);
    chk(skippedWord, 1);
    run(16'hB000, 0, OP_SKIP_CLR, 2, 0);
    run(16'hEF00, 0, OP_NOP, 1, 0);
    run(16'hF000, 0, OP_NOP, 1, 0);
    chk(skippedWord, 1);
    for (int j = 0; j < 16; j++)
      run({5'h1C, j[2:0], 8'h10}, {5{j < 8}}, OP_COND_BR, (j[0] ^ (j < 8)) ? 2 : 1, 0);
    run(16'h0F15, 0, OP_LIT_ADD, 1, MASK_ARITH);
    chk(literal, 12'h015);
    run(16'h0B01, 0, OP_LIT_AND, 1, MASK_LOGIC);
    run(16'h0901, 0, OP_LIT_IOR, 1, MASK_LOGIC);
    run(16'h0A01, 0, OP_LIT_XOR, 1, MASK_LOGIC);
    run(16'h0802, 0, OP_LIT_SUB, 1, MASK_ARITH);
    run(16'h0E03, 0, OP_LIT_MOV, 1, 0);
    run(16'h0D04, 0, OP_LIT_MUL, 1, 0);
    run(16'h0CAA, 0, OP_LIT_RET, 2, 0);
    run(16'h0107, 0, OP_BANK_LD, 1, 0);
    chk(literal, 7);
    run(16'h0006, 0, OP_POP, 1, 0);
    run(16'h0005, 0, OP_PUSH, 1, 0);
    run(16'h0011, 0, OP_IRQ_RET, 2, MASK_IRQ);
    run(16'h0012, 0, OP_RETURN, 2, 0);
    chk(fastSelect, 0);
    run(16'h0003, 0, OP_SLEEP, 1, MASK_POWER);
    run(16'h0004, 0, OP_WDT_CLR, 1, MASK_POWER);
    for (int j = 0; j < 8; j++) begin
      run(16'h0008 + j, 0, j < 4 ? OP_TBL_READ : OP_TBL_WRITE, 2, 0);
      chk(literal, j % 4);
    end
    FM.send(16'hEDB4, 0);
    run(16'hF012, 0, OP_CALL, 2, 0);
    chk({targetAddr, fastSelect}, 21'h02569);
    FM.send(16'hEF34, 0);
    run(16'hF567, 0, OP_GOTO, 2, 0);
    chk(targetAddr, 20'h56734);
    FM.send(16'hEE25, 0);
    run(16'hF0AB, 0, OP_PTR_LD, 2, 0);
    chk({fileAddr, literal}, 20'h025AB);
    run(16'hF123, 0, OP_NOP, 1, 0);
    chk(skippedWord, 0);
    bus(1, REG_PORT, 32'h0240);
    bus(1, REG_TIMER, 32'h50);
    bus(1, REG_CTRL, 3);
    run(16'h8041, 0, OP_BIT_SET, 1, 0);
    chk(usePinLevel, 1);
    run(16'h8042, 0, OP_BIT_SET, 1, 0);
    chk(usePinLevel, 0);
    run(16'h9050, 0, OP_BIT_CLEAR, 1, 0);
    chk(prescalerClear, 1);
    bus(1, REG_CTRL, 1);
    run(16'h7050, 0, OP_BIT_TGL, 1, 0);
    chk(prescalerClear, 0);
    bus(1, REG_CTRL, 0);
    FM.send(16'h0F15, 0);
    repeat (3) @(posedge sys_clk);
    chk(opClass, OP_BIT_TGL);
    give_verdict();
  end
endmodule

// *** logic/cond_eval.sv ***
// Branch condition and bit-test evaluator for the decoder
`timescale 1ns/1ns
module cond_eval (
  // Condition select
  input  wire logic [2:0] condCode,
  input  wire logic       skipWhenSet,
  // Core status and tested bit
  input  wire logic       zeroFlag,
  input  wire logic       carryFlag,
  input  wire logic       ovfFlag,
  input  wire logic       negFlag,
  input  wire logic       testBit,
  // Results
  output logic            branchTrue,
  output logic            skipTrue
);

  // ==========================================================================
  // Evaluation
  logic flagSel;  // Flag picked by the code's upper two bits

  // Even codes test the flag set, odd codes test it clear
  // Skip polarity arrives already resolved by the caller
  always_comb begin
    unique case (condCode[2:1])
      2'h0: flagSel = zeroFlag;
      2'h1: flagSel = carryFlag;
      2'h2: flagSel = ovfFlag;
      2'h3: flagSel = negFlag;
    endcase
    branchTrue = flagSel ^ condCode[0];
    skipTrue   = skipWhenSet ? testBit : ~testBit;
  end

endmodule

// *** logic/instr_decode_pkg.sv ***
// Shared constants, encodings and register map of the instruction word decoder
package instr_decode_pkg;

  // ==========================================================================
  // Word and field widths
  localparam int WORD_W = 16;
  localparam int LIT_W  = 12;
  localparam int TGT_W  = 20;
  localparam int MASK_W = 8;

  // ==========================================================================
  // Top nibble encodings
  localparam logic [3:0] NIB_ZERO     = 4'h0;
  localparam logic [3:0] NIB_BIT_TGL  = 4'h7;
  localparam logic [3:0] NIB_BIT_SET  = 4'h8;
  localparam logic [3:0] NIB_BIT_CLR  = 4'h9;
  localparam logic [3:0] NIB_SKIP_SET = 4'hA;
  localparam logic [3:0] NIB_SKIP_CLR = 4'hB;
  localparam logic [3:0] NIB_CTRL     = 4'hE;
  localparam logic [3:0] NIB_EXT      = 4'hF;

  // Second nibble encodings
  localparam logic [2:0] SUB_CALL  = 3'h6;
  localparam logic [3:0] SUB_GOTO  = 4'hF;
  localparam logic [5:0] SUB_PTR   = 6'h38;
  localparam logic [3:0] SUB_BANK  = 4'h1;
  localparam logic [3:0] SUB_LSUB  = 4'h8;
  localparam logic [3:0] SUB_LIOR  = 4'h9;
  localparam logic [3:0] SUB_LXOR  = 4'hA;
  localparam logic [3:0] SUB_LAND  = 4'hB;
  localparam logic [3:0] SUB_LRET  = 4'hC;
  localparam logic [3:0] SUB_LMUL  = 4'hD;
  localparam logic [3:0] SUB_LMOV  = 4'hE;
  localparam logic [3:0] SUB_LADD  = 4'hF;

  // Low byte encodings under an all-zero upper byte
  localparam logic [7:0] LOW_NOP    = 8'h00;
  localparam logic [7:0] LOW_SLEEP  = 8'h03;
  localparam logic [7:0] LOW_WDT    = 8'h04;
  localparam logic [7:0] LOW_PUSH   = 8'h05;
  localparam logic [7:0] LOW_POP    = 8'h06;
  localparam logic [6:0] LOW_IRET   = 7'h08;
  localparam logic [6:0] LOW_RET    = 7'h09;
  localparam logic [5:0] LOW_TBL_RD = 6'h02;
  localparam logic [5:0] LOW_TBL_WR = 6'h03;

  // ==========================================================================
  // Affected-flag mask bits and groups
  localparam logic [7:0] MASK_NONE  = 8'h00;
  localparam logic [7:0] MASK_ARITH = 8'h1F;
  localparam logic [7:0] MASK_LOGIC = 8'h14;
  localparam logic [7:0] MASK_POWER = 8'h60;
  localparam logic [7:0] MASK_IRQ   = 8'h80;

  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_PORT  = 8'h04;
  localparam logic [7:0] REG_TIMER = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;

  // Control fields and reset values
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_PRE_BIT  = 1;
  localparam logic [1:0] CTRL_RST      = 2'h1;
  localparam logic [7:0] PORT_BASE_RST = 8'h80;
  localparam logic [7:0] PORT_CNT_RST  = 8'h05;
  localparam logic [7:0] TIMER_RST     = 8'h00;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================================
  // Decoded opcode classes
  typedef enum logic [4:0] {
    OP_NOP       = 5'h00, OP_BIT_CLEAR = 5'h01, OP_BIT_SET   = 5'h02,
    OP_BIT_TGL   = 5'h03, OP_SKIP_CLR  = 5'h04, OP_SKIP_SET  = 5'h05,
    OP_COND_BR   = 5'h06, OP_CALL      = 5'h07, OP_GOTO      = 5'h08,
    OP_POP       = 5'h09, OP_PUSH      = 5'h0A, OP_IRQ_RET   = 5'h0B,
    OP_RETURN    = 5'h0C, OP_SLEEP     = 5'h0D, OP_WDT_CLR   = 5'h0E,
    OP_LIT_RET   = 5'h0F, OP_LIT_ADD   = 5'h10, OP_LIT_AND   = 5'h11,
    OP_LIT_IOR   = 5'h12, OP_LIT_XOR   = 5'h13, OP_LIT_SUB   = 5'h14,
    OP_LIT_MOV   = 5'h15, OP_LIT_MUL   = 5'h16, OP_BANK_LD   = 5'h17,
    OP_PTR_LD    = 5'h18, OP_TBL_READ  = 5'h19, OP_TBL_WRITE = 5'h1A,
    OP_OTHER     = 5'h1F
  } op_class_e;

  // Word sequencer states
  typedef enum logic [1:0] {
    ST_FIRST    = 2'b00,
    ST_EXT      = 2'b01,
    ST_SKIP     = 2'b10,
    ST_SKIP_EXT = 2'b11
  } seq_state_e;

endpackage

// *** logic/instr_word_decoder.sv ***
// Instruction word decoder: bit, control, literal and table classes
`timescale 1ns/1ns
module instr_word_decoder
  import instr_decode_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Fetch stage
  input  wire logic [WORD_W-1:0]   instrWord,
  input  wire logic                instrValid,
  // Datapath status
  input  wire logic                zeroFlag,
  input  wire logic                carryFlag,
  input  wire logic                ovfFlag,
  input  wire logic                negFlag,
  input  wire logic                testBit,
  // Decoded outputs
  output logic                     decodeValid,
  output op_class_e                opClass,
  output logic [7:0]               fileAddr,
  output logic [2:0]               bitIndex,
  output logic                     destBit,
  output logic                     accessBit,
  output logic [LIT_W-1:0]         literal,
  output logic [TGT_W-1:0]         targetAddr,
  output logic                     fastSelect,
  output logic [1:0]               cycleCount,
  output logic [MASK_W-1:0]        flagMask,
  output logic                     skippedWord,
  output logic                     usePinLevel,
  output logic                     prescalerClear,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp
);
  import instr_decode_pkg::*;

  // ==========================================================================
  // Register file state
  logic [1:0]  ctrl_q;       // Decode enable, prescaler assigned
  logic [7:0]  portBase_q;   // First port register address
  logic [7:0]  portCnt_q;    // Number of port registers
  logic [7:0]  timerAddr_q;  // Timer-zero register address
  logic [31:0] count_q;      // Count of decodeValid pulses so far
  logic        wrPend_q;     // Write data phase pending
  logic [7:0]  wrAddr_q;     // Latched write address

  // ==========================================================================
  // Sequencer state
  seq_state_e        state_q;      // Where the next word belongs
  logic [WORD_W-1:0] firstWord_q;  // Held opener of a two-word pair

  // ==========================================================================
  // Combinational decode of the incoming word
  op_class_e         classD;
  logic [1:0]        cycD;
  logic [7:0]        maskD;
  logic [7:0]        fileD;
  logic              destD;
  logic [LIT_W-1:0]  litD;
  logic              fastD;
  logic              opensExt;  // Word needs a 1111 extension
  logic              skipOp;    // Word is a bit test-skip
  logic              branchTrue;
  logic              skipTrue;
  logic              accept;

  assign accept = instrValid & ctrl_q[CTRL_EN_BIT];

  // Flag evaluation, shared by branches and test-skips
  cond_eval condUnit (
    .condCode    (instrWord[10:8]),
    .skipWhenSet (~instrWord[12]), // 1010 skips on set, 1011 on clear
    .zeroFlag    (zeroFlag),
    .carryFlag   (carryFlag),
    .ovfFlag     (ovfFlag),
    .negFlag     (negFlag),
    .testBit     (testBit),
    .branchTrue  (branchTrue),
    .skipTrue    (skipTrue)
  );

  // Single-word field decode; byte ops and relative jumps fall to OTHER
  always_comb begin
    classD   = OP_OTHER;
    cycD     = CYC_ONE;
    maskD    = MASK_NONE;
    fileD    = instrWord[7:0];
    destD    = 1'b0;
    litD     = {4'h0, instrWord[7:0]};
    fastD    = 1'b0;
    opensExt = 1'b0;
    skipOp   = 1'b0;
    unique case (instrWord[15:12])
      NIB_BIT_CLR: begin
        classD = OP_BIT_CLEAR;
        destD  = 1'b1;
      end
      NIB_BIT_SET: begin
        classD = OP_BIT_SET;
        destD  = 1'b1;
      end
      NIB_BIT_TGL: begin
        classD = OP_BIT_TGL;
        destD  = 1'b1;
      end
      NIB_SKIP_CLR, NIB_SKIP_SET: begin
        classD = instrWord[12] ? OP_SKIP_CLR : OP_SKIP_SET;
        skipOp = 1'b1;
        cycD   = skipTrue ? CYC_TWO : CYC_ONE;
      end
      NIB_CTRL: begin
        if (!instrWord[11]) begin
          classD = OP_COND_BR;
          cycD   = branchTrue ? CYC_TWO : CYC_ONE;
        end else if (instrWord[11:9] == SUB_CALL) begin
          classD   = OP_CALL;
          fastD    = instrWord[8];
          opensExt = 1'b1;
        end else if (instrWord[11:8] == SUB_GOTO) begin
          classD   = OP_GOTO;
          opensExt = 1'b1;
        end else if (instrWord[11:6] == SUB_PTR) begin
          classD   = OP_PTR_LD;
          opensExt = 1'b1;
        end
      end
      // Lone extension words are harmless fillers
      NIB_EXT: classD = OP_NOP;
      NIB_ZERO: begin
        unique case (instrWord[11:8])
          4'h0: begin
            if (instrWord[7:0] == LOW_NOP) begin
              classD = OP_NOP;
            end else if (instrWord[7:0] == LOW_SLEEP) begin
              classD = OP_SLEEP;
              maskD  = MASK_POWER;
            end else if (instrWord[7:0] == LOW_WDT) begin
              classD = OP_WDT_CLR;
              maskD  = MASK_POWER;
            end else if (instrWord[7:0] == LOW_PUSH) begin
              classD = OP_PUSH;
            end else if (instrWord[7:0] == LOW_POP) begin
              classD = OP_POP;
            end else if (instrWord[7:1] == LOW_IRET) begin
              classD = OP_IRQ_RET;
              cycD   = CYC_TWO;
              fastD  = instrWord[0];
              maskD  = MASK_IRQ;
            end else if (instrWord[7:1] == LOW_RET) begin
              classD = OP_RETURN;
              cycD   = CYC_TWO;
              fastD  = instrWord[0];
            end else if (instrWord[7:2] == LOW_TBL_RD) begin
              classD = OP_TBL_READ;
              cycD   = CYC_TWO;
              litD   = {10'h000, instrWord[1:0]};
            end else if (instrWord[7:2] == LOW_TBL_WR) begin
              classD = OP_TBL_WRITE;
              cycD   = CYC_TWO;
              litD   = {10'h000, instrWord[1:0]};
            end
          end
          SUB_BANK: begin
            if (instrWord[7:4] == 4'h0) begin
              classD = OP_BANK_LD;
              litD   = {8'h00, instrWord[3:0]};
            end
          end
          SUB_LSUB: begin
            classD = OP_LIT_SUB;
            maskD  = MASK_ARITH;
          end
          SUB_LIOR: begin
            classD = OP_LIT_IOR;
            maskD  = MASK_LOGIC;
          end
          SUB_LXOR: begin
            classD = OP_LIT_XOR;
            maskD  = MASK_LOGIC;
          end
          SUB_LAND: begin
            classD = OP_LIT_AND;
            maskD  = MASK_LOGIC;
          end
          SUB_LRET: begin
            classD = OP_LIT_RET;
            cycD   = CYC_TWO;
          end
          SUB_LMUL: classD = OP_LIT_MUL;
          SUB_LMOV: classD = OP_LIT_MOV;
          SUB_LADD: begin
            classD = OP_LIT_ADD;
            maskD  = MASK_ARITH;
          end
          // Byte-oriented file operations are not decoded here
          default: classD = OP_OTHER;
        endcase
      end
      // Byte ops and relative jumps live outside this decoder
      default: classD = OP_OTHER;
    endcase
  end

  // ==========================================================================
  // Word sequencer: pairs openers with extensions, swallows skipped words
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_FIRST;
      firstWord_q <= 16'h0000;
    end else if (accept) begin
      unique case (state_q)
        ST_FIRST: begin
          if (opensExt) begin
            state_q     <= ST_EXT;
            firstWord_q <= instrWord;
          end else if (skipOp && skipTrue) begin
            state_q <= ST_SKIP;
          end
        end
        ST_EXT: state_q <= ST_FIRST;
        // A skipped opener drags its extension along
        ST_SKIP: state_q <= opensExt ? ST_SKIP_EXT : ST_FIRST;
        ST_SKIP_EXT: state_q <= ST_FIRST;
      endcase
    end
  end

  // ==========================================================================
  // Decoded output registers, loaded once per accepted word except the opener of a pair
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      decodeValid <= 1'b0;
      opClass     <= OP_NOP;
      fileAddr    <= 8'h00;
      bitIndex    <= 3'h0;
      destBit     <= 1'b0;
      accessBit   <= 1'b0;
      literal     <= 12'h000;
      targetAddr  <= 20'h00000;
      fastSelect  <= 1'b0;
      cycleCount  <= CYC_ONE;
      flagMask    <= MASK_NONE;
      skippedWord <= 1'b0;
    end else begin
      decodeValid <= 1'b0;
      if (accept && !(state_q == ST_FIRST && opensExt)) begin
        decodeValid <= 1'b1;
        skippedWord <= 1'b0;
        unique case (state_q)
          ST_FIRST: begin
            opClass    <= classD;
            fileAddr   <= fileD;
            bitIndex   <= instrWord[11:9];
            destBit    <= destD;
            accessBit  <= instrWord[8];
            literal    <= litD;
            fastSelect <= fastD;
            cycleCount <= cycD;
            flagMask   <= maskD;
          end
          ST_EXT: begin
            // A missing 1111 prefix leaves the pair undefined
            opClass    <= (instrWord[15:12] == NIB_EXT) ? classOf(firstWord_q) : OP_OTHER;
            fileAddr   <= {6'h00, firstWord_q[5:4]};
            literal    <= {firstWord_q[3:0], instrWord[7:0]};
            targetAddr <= {instrWord[11:0], firstWord_q[7:0]};
            fastSelect <= firstWord_q[8] & ~firstWord_q[9];
            cycleCount <= CYC_TWO;
            flagMask   <= MASK_NONE;
            destBit    <= 1'b0;
          end
          ST_SKIP, ST_SKIP_EXT: begin
            // Discarded word runs as a no-op cycle
            opClass     <= OP_NOP;
            skippedWord <= 1'b1;
            cycleCount  <= CYC_ONE;
            flagMask    <= MASK_NONE;
            destBit     <= 1'b0;
          end
        endcase
      end
    end
  end

  // Class of a held opener, recomputed so the pair needs no extra flop
  function automatic op_class_e classOf(input logic [WORD_W-1:0] w);
    op_class_e c;
    c = OP_PTR_LD;
    if (w[11:9] == SUB_CALL) begin
      c = OP_CALL;
    end else if (w[11:8] == SUB_GOTO) begin
      c = OP_GOTO;
    end
    return c;
  endfunction

  // ==========================================================================
  // Port and timer side effects of bit writes
  logic portHit;   // Bit write lands on a port register
  logic timerHit;  // Bit write lands on the timer-zero register
  logic bitWrite;

  assign bitWrite = (state_q == ST_FIRST) & destD;
  assign portHit  = (instrWord[7:0] >= portBase_q) &&
                    ({1'b0, instrWord[7:0]} < ({1'b0, portBase_q} + {1'b0, portCnt_q}));
  assign timerHit = instrWord[7:0] == timerAddr_q;

  // Pin levels feed read-modify-write of ports; prescaler clear is a pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      usePinLevel    <= 1'b0;
      prescalerClear <= 1'b0;
    end else begin
      prescalerClear <= 1'b0;
      if (accept && !(state_q == ST_FIRST && opensExt)) begin
        usePinLevel    <= bitWrite & portHit;
        prescalerClear <= bitWrite & timerHit & ctrl_q[CTRL_PRE_BIT];
      end
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait states, read data captured in address phase
  logic addrPhase;
  logic [31:0] rdMux;

  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    unique case (haddr[7:0])
      REG_CTRL:  rdMux = {30'h0, ctrl_q};
      REG_PORT:  rdMux = {16'h0, portCnt_q, portBase_q};
      REG_TIMER: rdMux = {24'h0, timerAddr_q};
      REG_STATE: rdMux = {22'h0, state_q, cycleCount, 1'b0, opClass};
      REG_COUNT: rdMux = count_q;
      default:   rdMux = 32'h0000_0000;
    endcase
  end

  // Bus response flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr[7:0];
        hrdata   <= hwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // Writable registers, written in the data phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q      <= CTRL_RST;
      portBase_q  <= PORT_BASE_RST;
      portCnt_q   <= PORT_CNT_RST;
      timerAddr_q <= TIMER_RST;
    end else if (wrPend_q) begin
      if (wrAddr_q == REG_CTRL) begin
        ctrl_q <= hwdata[1:0];
      end
      if (wrAddr_q == REG_PORT) begin
        portBase_q <= hwdata[7:0];
        portCnt_q  <= hwdata[15:8];
      end
      if (wrAddr_q == REG_TIMER) begin
        timerAddr_q <= hwdata[7:0];
      end
    end
  end

  // Counter of decodeValid pulses, wraps silently
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 32'h0000_0000;
    end else if (decodeValid) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

endmodule
